// *** rtl/stsr_device.sv ***
// Device end: tone select, detection report and code squelch
`timescale 1ns/100ps
`include "stsr_consts.svh"
module stsr_device #(
   parameter int CS_BIT_CYCLES = int'(`STSR_CS_BIT_CYCLES)
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   stsr_if.dev bus,
   input wire logic [5:0] rxTone,
   input wire stsr_pkg::stsr_freq_t userFreq,
   input wire logic csData,
   input wire logic [23:0] csPattern,
   input wire logic cs24,
   output logic genOn,
   output stsr_pkg::stsr_freq_t genFreq,
   output logic scanEn,
   output logic scanAll,
   output stsr_pkg::stsr_freq_t scanFreq,
   output logic csMatch
);
   import stsr_pkg::*;

   stsr_dev_t state_r;
   stsr_dev_t state_nxt;
   stsr_freq_t mapFreq;
   logic mapKnown;
   stsr_code_t selCode;
   stsr_code_t rxCode;
   stsr_code_t newReport;
   logic toneDetOn;
   logic codeSqOn;
   logic selIsTone;
   logic csTick;
   logic [23:0] csMask;
   logic [23:0] csBits;
   logic csHit;
   logic irqEvent;
   logic irqClear;
   logic toneValid;

   assign selCode = state_r.sel[7:0];

   stsr_tone_map u_map (
      .code(selCode),
      .userFreq(userFreq),
      .freq(mapFreq),
      .known(mapKnown)
   );

   always_comb begin
      state_nxt = state_r;

      // Tone squelch takes the receiver; code squelch only runs without it
      toneDetOn = state_r.fen[`STSR_FEN_TONE_DET];
      codeSqOn = state_r.fen[`STSR_FEN_CODE_SQ] & ~toneDetOn;
      selIsTone = (selCode >= `STSR_CODE_FIRST) && mapKnown;

      // Detector number n maps to code 200 + n
      rxCode = `STSR_CODE_LEARN + {2'b00, rxTone};
      // Numbers above 54 would take rxCode to 255 or wrap it past 255, so they are tested on rxTone

      // Classify what the detector hears
      if (!toneDetOn || rxTone == 6'h00) begin
         newReport = `STSR_CODE_NONE;
      end else if (rxCode == `STSR_CODE_ALLCALL) begin
         newReport = `STSR_CODE_ALLCALL;
      end else if (rxTone > 6'h36) begin
         newReport = `STSR_CODE_INVALID;
      end else if (selCode == `STSR_CODE_NONE) begin
         newReport = `STSR_CODE_NONE;
      end else if (selCode == `STSR_CODE_LEARN) begin
         // Learned result is a tone number, never the learning code
         if (rxCode <= `STSR_CODE_LAST_LEARN) begin
            newReport = rxCode;
         end else begin
            newReport = `STSR_CODE_INVALID;
         end
      end else if (selCode == rxCode) begin
         newReport = rxCode;
      end else begin
         newReport = `STSR_CODE_INVALID;
      end

      // Only entry into or exit from no-tone raises the interrupt
      irqEvent = ((state_r.report == `STSR_CODE_NONE) != (newReport == `STSR_CODE_NONE))
         && state_r.fen[`STSR_FEN_IRQ];
      irqClear = bus.rdEn && bus.addr == `STSR_ADDR_REPORT;
      state_nxt.report = newReport;
      if (irqEvent) begin
         state_nxt.irq = 1'b1;
      end else if (irqClear) begin
         state_nxt.irq = 1'b0;
      end

      toneValid = state_r.report != `STSR_CODE_NONE && state_r.report != `STSR_CODE_INVALID;

      // Register writes
      if (bus.wrEn) begin
         case (bus.addr)
            `STSR_ADDR_FEN: begin
               state_nxt.fen = bus.wData;
            end
            `STSR_ADDR_SEL: begin
               state_nxt.sel = bus.wData;
            end
            default: begin
               state_nxt.fen = state_r.fen;
            end
         endcase
      end

      // Register reads answer one cycle later; write-only ones read zero
      state_nxt.rValid = bus.rdEn;
      state_nxt.rData = 16'h0000;
      if (bus.rdEn) begin
         case (bus.addr)
            `STSR_ADDR_REPORT: begin
               state_nxt.rData = {8'h00, state_r.report};
            end
            `STSR_ADDR_STATUS: begin
               state_nxt.rData[`STSR_STAT_TONE] = toneValid;
               state_nxt.rData[`STSR_STAT_CODE_SQ] = state_r.csMatch;
            end
            default: begin
               state_nxt.rData = 16'h0000;
            end
         endcase
      end

      // Generator: silent for no-tone, learning and non-tone codes
      state_nxt.genOn = state_r.fen[`STSR_FEN_TONE_TX] && selIsTone;
      state_nxt.genFreq = selIsTone ? mapFreq : 12'h000;

      // Detector steering
      state_nxt.scanEn = toneDetOn;
      state_nxt.scanAll = toneDetOn && selCode == `STSR_CODE_LEARN;
      state_nxt.scanFreq = (toneDetOn && selIsTone) ? mapFreq : 12'h000;

      // Code squelch bit clock from a divider, data line synchronised
      state_nxt.csSync = {state_r.csSync[0], csData};
      csTick = state_r.divCnt >= 32'(CS_BIT_CYCLES - 1);
      if (!codeSqOn || csTick) begin
         state_nxt.divCnt = 32'h0000_0000;
      end else begin
         state_nxt.divCnt = state_r.divCnt + 32'h0000_0001;
      end
      // Least significant bit arrives first, so shift toward bit 0
      csBits = {state_r.csSync[1], state_r.csShift[23:1]};
      csMask = cs24 ? 24'hff_ffff : 24'h7f_ffff;
      if (cs24) begin
         csHit = ((csBits ^ csPattern) & csMask) == 24'h00_0000
            || ((csBits ^ ~csPattern) & csMask) == 24'h00_0000;
      end else begin
         csHit = ((csBits[23:1] ^ csPattern[22:0]) & csMask[22:0]) == 23'h00_0000
            || ((csBits[23:1] ^ ~csPattern[22:0]) & csMask[22:0]) == 23'h00_0000;
      end
      if (!codeSqOn) begin
         state_nxt.csMatch = 1'b0;
         state_nxt.csShift = 24'h00_0000;
      end else if (csTick) begin
         state_nxt.csShift = csBits;
         state_nxt.csMatch = csHit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= '0;
         state_r.fen <= `STSR_FEN_RESET;
         state_r.sel <= `STSR_SEL_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign bus.rData = state_r.rData;
   assign bus.rValid = state_r.rValid;
   assign bus.toneIrq = state_r.irq;
   assign genOn = state_r.genOn;
   assign genFreq = state_r.genFreq;
   assign scanEn = state_r.scanEn;
   assign scanAll = state_r.scanAll;
   assign scanFreq = state_r.scanFreq;
   assign csMatch = state_r.csMatch;
endmodule : stsr_device

// *** rtl/stsr_consts.svh ***
// Constants of the sub-audio tone select and report block
`ifndef STSR_CONSTS_SVH
`define STSR_CONSTS_SVH
`define STSR_ADDR_FEN 8'hc1
`define STSR_ADDR_SEL 8'hc2
`define STSR_ADDR_STATUS 8'hc6
`define STSR_ADDR_REPORT 8'hcc
`define STSR_FEN_TONE_DET 0
`define STSR_FEN_CODE_SQ 1
`define STSR_FEN_IRQ 2
`define STSR_FEN_TONE_TX 3
`define STSR_STAT_CODE_SQ 10
`define STSR_STAT_TONE 11
`define STSR_FEN_RESET 16'h0000
`define STSR_SEL_RESET 16'h0000
`define STSR_CODE_NONE 8'h00
`define STSR_CODE_LEARN 8'hc8
`define STSR_CODE_FIRST 8'hc9
`define STSR_CODE_LAST_LEARN 8'hef
`define STSR_CODE_ALLCALL 8'hf0
`define STSR_CODE_LAST_TONE 8'hfb
`define STSR_CODE_USER 8'hfc
`define STSR_CODE_EXT 8'hfd
`define STSR_CODE_CSOFF 8'hfe
`define STSR_CODE_INVALID 8'hff
`define STSR_FREQ_EXT 12'h287
`define STSR_FREQ_CSOFF 12'h540
`define STSR_CLK_HZ 64'h2625a00
`define STSR_CS_RATE_DBPS 64'h540
`define STSR_CS_BIT_CYCLES (`STSR_CLK_HZ * 64'ha / `STSR_CS_RATE_DBPS)
`endif

// *** rtl/stsr_pkg.sv ***
// Types of the sub-audio tone select and report block
package stsr_pkg;
   typedef logic [7:0] stsr_code_t;
   typedef logic [11:0] stsr_freq_t;
   typedef struct packed {
      logic [15:0] fen;
      logic [15:0] sel;
      stsr_code_t report;
      logic irq;
      logic [15:0] rData;
      logic rValid;
      logic [1:0] csSync;
      logic [23:0] csShift;
      logic csMatch;
      logic [31:0] divCnt;
      logic genOn;
      stsr_freq_t genFreq;
      logic scanEn;
      logic scanAll;
      stsr_freq_t scanFreq;
   } stsr_dev_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_IRQRD, HOST_USERRD} stsr_hstate_t;
   typedef struct packed {
      stsr_hstate_t state;
      logic learning;
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [15:0] wData;
      logic rspValid;
      logic [15:0] rspData;
      stsr_code_t lastReport;
   } stsr_host_t;
endpackage : stsr_pkg

// *** rtl/stsr_if.sv ***
// Register link between host and tone block
`timescale 1ns/100ps
interface stsr_if;
   logic wrEn;
   logic rdEn;
   logic [7:0] addr;
   logic [15:0] wData;
   logic [15:0] rData;
   logic rValid;
   logic toneIrq;
   modport dev (input wrEn, input rdEn, input addr, input wData,
      output rData, output rValid, output toneIrq);
   modport host (output wrEn, output rdEn, output addr, output wData,
      input rData, input rValid, input toneIrq);
endinterface : stsr_if

// *** rtl/stsr_tone_map.sv ***
// Tone code to frequency map, in tenths of a hertz
`timescale 1ns/100ps
`include "stsr_consts.svh"
module stsr_tone_map (
   input wire stsr_pkg::stsr_code_t code,
   input wire stsr_pkg::stsr_freq_t userFreq,
   output stsr_pkg::stsr_freq_t freq,
   output logic known
);
   import stsr_pkg::*;
   // Tone 51 first, tone 1 last
   localparam logic [51*12-1:0] FREQ_TABLE = {
      12'h9ed, 12'h8f3, 12'h811, 12'h7cb, 12'h7ae, 12'h76b, 12'h72b, 12'h6ed,
      12'h6b1, 12'h677, 12'h63e, 12'h271, 12'h2b5, 12'h9c7, 12'h972, 12'h920,
      12'h8d1, 12'h885, 12'h83b, 12'h7f3, 12'h788, 12'h746, 12'h707, 12'h6ca,
      12'h68f, 12'h656, 12'h61f, 12'h5ea, 12'h5b6, 12'h585, 12'h555, 12'h526,
      12'h4f9, 12'h4ce, 12'h4a4, 12'h47c, 12'h455, 12'h430, 12'h40b, 12'h3e8,
      12'h3ce, 12'h3b4, 12'h393, 12'h375, 12'h356, 12'h339, 12'h31d, 12'h302,
      12'h2e8, 12'h2cf, 12'h29e};
   logic [7:0] idx;
   always_comb begin
      idx = code - `STSR_CODE_FIRST;
      freq = 12'h000;
      known = 1'b1;
      if (code >= `STSR_CODE_FIRST && code <= `STSR_CODE_LAST_TONE) begin
         freq = FREQ_TABLE[12*idx +: 12];
      end else if (code == `STSR_CODE_USER) begin
         freq = userFreq;
      end else if (code == `STSR_CODE_EXT) begin
         freq = `STSR_FREQ_EXT;
      end else if (code == `STSR_CODE_CSOFF) begin
         freq = `STSR_FREQ_CSOFF;
      end else begin
         known = 1'b0;
      end
   end
endmodule : stsr_tone_map

// *** rtl/stsr_host.sv ***
// Host end: register access and adoption of a learned tone
`timescale 1ns/100ps
`include "stsr_consts.svh"
module stsr_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   stsr_if.host bus,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdAddr,
   input wire logic [15:0] cmdData,
   output logic cmdReady,
   input wire logic autoAdopt,
   output logic rspValid,
   output logic [15:0] rspData,
   output stsr_pkg::stsr_code_t lastReport,
   output logic toneIrq
);
   import stsr_pkg::*;

   stsr_host_t state_r;
   stsr_host_t state_nxt;
   stsr_code_t rep;

   // Interrupt service takes priority over user commands
   assign cmdReady = state_r.state == HOST_IDLE && !bus.toneIrq && !state_r.wrEn;

   always_comb begin
      state_nxt = state_r;
      state_nxt.wrEn = 1'b0;
      state_nxt.rdEn = 1'b0;
      state_nxt.rspValid = 1'b0;
      rep = bus.rData[7:0];
      case (state_r.state)
         HOST_IDLE: begin
            if (bus.toneIrq && !state_r.wrEn) begin
               state_nxt.rdEn = 1'b1;
               state_nxt.addr = `STSR_ADDR_REPORT;
               state_nxt.state = HOST_IRQRD;
            end else if (cmdValid && cmdReady) begin
               state_nxt.addr = cmdAddr;
               state_nxt.wData = cmdData;
               if (cmdWrite) begin
                  state_nxt.wrEn = 1'b1;
                  if (cmdAddr == `STSR_ADDR_SEL) begin
                     state_nxt.learning = cmdData[7:0] == `STSR_CODE_LEARN;
                  end
               end else begin
                  state_nxt.rdEn = 1'b1;
                  state_nxt.state = HOST_USERRD;
               end
            end
         end
         HOST_IRQRD: begin
            if (bus.rValid) begin
               state_nxt.lastReport = rep;
               state_nxt.state = HOST_IDLE;
               // A learned tone is written back as the new selection
               if (autoAdopt && state_r.learning && rep >= `STSR_CODE_FIRST
                  && rep <= `STSR_CODE_LAST_LEARN) begin
                  state_nxt.wrEn = 1'b1;
                  state_nxt.addr = `STSR_ADDR_SEL;
                  state_nxt.wData = {8'h00, rep};
                  state_nxt.learning = 1'b0;
               end
            end
         end
         HOST_USERRD: begin
            if (bus.rValid) begin
               state_nxt.rspValid = 1'b1;
               state_nxt.rspData = bus.rData;
               state_nxt.state = HOST_IDLE;
            end
         end
         default: begin
            state_nxt.state = HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= '0;
         state_r.state <= HOST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign bus.wrEn = state_r.wrEn;
   assign bus.rdEn = state_r.rdEn;
   assign bus.addr = state_r.addr;
   assign bus.wData = state_r.wData;
   assign rspValid = state_r.rspValid;
   assign rspData = state_r.rspData;
   assign lastReport = state_r.lastReport;
   assign toneIrq = bus.toneIrq;
endmodule : stsr_host

// *** sim/stsr_assertions.sv ***
// Concurrent checks on the register link between host and tone block
`timescale 1ns/100ps
module stsr_assertions (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] addr,
   input wire logic [15:0] wData,
   input wire logic [15:0] rData,
   input wire logic rValid,
   input wire logic toneIrq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   rd_answer_a: assert property (rdEn |=> rValid)
      else $error("read strobe got no answer");
   answer_cause_a: assert property (rValid |-> $past(rdEn))
      else $error("read answer without a read strobe");
   idle_data_a: assert property (!rValid |-> rData == 16'h0000)
      else $error("read data not zero outside an answer");
   learn_hidden_a: assert property (rValid && $past(addr) == 8'hcc |-> rData[7:0] != 8'hc8)
      else $error("learning code seen in the report");
   wo_zero_a: assert property (rValid && $past(addr) inside {8'hc1, 8'hc2} |-> rData == 16'h0000)
      else $error("write-only register read back nonzero");
   one_access_a: assert property ((wrEn || rdEn) |-> !(wrEn && rdEn) ##1 !(wrEn || rdEn))
      else $error("bus strobes overlap or stretch");
   // Set wins over read-clear, so stimulus keeps tone edges away from the interrupt read
   irq_hold_a: assert property (toneIrq && !(rdEn && addr == 8'hcc) |=> toneIrq)
      else $error("tone interrupt dropped without a report read");
   irq_clear_a: assert property (toneIrq && rdEn && addr == 8'hcc |=> !toneIrq)
      else $error("tone interrupt not cleared by report read");
   irq_service_a: assert property ($rose(toneIrq) |-> ##[1:6] (rdEn && addr == 8'hcc))
      else $error("host did not read the report after an interrupt");
endmodule : stsr_assertions

// *** sim/subaudio_tone_select_report_tb.sv ***
// Self-checking bench for the sub-audio tone select and report pair
`timescale 1ns/100ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module subaudio_tone_select_report_tb;
   import stsr_pkg::*;
   logic clk_sys, rst_n, cmdValid, cmdWrite, cmdReady, autoAdopt, rspValid, toneIrq;
   logic genOn, scanEn, scanAll, csMatch, csData, cs24, hit;
   logic [7:0] cmdAddr;
   logic [15:0] cmdData, rspData;
   logic [5:0] rxTone;
   logic [23:0] csPattern;
   stsr_code_t lastReport;
   stsr_freq_t genFreq, scanFreq, userFreq;
   int errors = 0;
   int nChecks = 0;
   int cyc = 0;
   logic [23:0] txTab [9] = '{24'hc9129e, 24'hef12b5, 24'hf01271, 24'hfb19ed, 24'hfc13e8,
      24'hfd1287, 24'hfe1540, 24'h000000, 24'hc80000};
   stsr_if bus ();
   stsr_device #(.CS_BIT_CYCLES(8)) u_stsr_device (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
      .rxTone(rxTone), .userFreq(userFreq), .csData(csData), .csPattern(csPattern), .cs24(cs24),
      .genOn(genOn), .genFreq(genFreq), .scanEn(scanEn), .scanAll(scanAll),
      .scanFreq(scanFreq), .csMatch(csMatch));
   stsr_host u_stsr_host (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
      .autoAdopt(autoAdopt), .rspValid(rspValid), .rspData(rspData),
      .lastReport(lastReport), .toneIrq(toneIrq));
   stsr_assertions u_stsr_assertions (.clk_sys(clk_sys), .rst_n(rst_n), .wrEn(bus.wrEn),
      .rdEn(bus.rdEn), .addr(bus.addr), .wData(bus.wData), .rData(bus.rData),
      .rValid(bus.rValid), .toneIrq(bus.toneIrq));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic endSim();
      $display("checks %0d mismatches %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : endSim
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 10000) begin
         errors++;
         endSim();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic cmd(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdAddr <= a;
      cmdData <= d;
      @(posedge clk_sys);
      while (cmdReady !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK(cmdReady, 1'b1)
      cmdValid <= 1'b0;
   endtask : cmd
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      cmd(1'b1, a, d);
      tick(4);
   endtask : wr
   task automatic rdChk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      int n;
      n = 0;
      cmd(1'b0, a, 16'h0000);
      do begin
         @(posedge clk_sys);
         n++;
      end while (rspValid !== 1'b1 && n < 10);
      `CHK(rspValid, 1'b1)
      `CHK(rspData & m, e)
   endtask : rdChk
   task automatic tone(input logic [5:0] t, input stsr_code_t e);
      rxTone <= t;
      tick(12);
      `CHK(lastReport, e)
      `CHK(toneIrq, 1'b0)
   endtask : tone
   // Hit counts from the second pass: a match left from the last feed lingers until a bit tick
   task automatic csFeed(input logic [23:0] p, input int len, input logic inv);
      hit = 1'b0;
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < len; i++) begin
            csData <= p[i] ^ inv;
            repeat (8) begin
               @(posedge clk_sys);
               hit = hit | (r > 0 && csMatch === 1'b1);
            end
         end
      end
   endtask : csFeed
   initial begin
      rst_n = 1'b0;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdAddr = 8'h00;
      cmdData = 16'h0000;
      autoAdopt = 1'b0;
      rxTone = 6'h00;
      userFreq = 12'h3e8;
      csData = 1'b0;
      csPattern = 24'h763813;
      cs24 = 1'b0;
      tick(3);
      rst_n <= 1'b1;
      rdChk(8'hcc, 16'h00ff, 16'h0000);
      rdChk(8'hc1, 16'hffff, 16'h0000);
      rdChk(8'h10, 16'hffff, 16'h0000);
      done("reset");
      wr(8'hc1, 16'h0008);
      `CHK(scanEn, 1'b0)
      foreach (txTab[i]) begin
         wr(8'hc2, {8'h00, txTab[i][23:16]});
         `CHK(genOn, txTab[i][12])
         `CHK(genFreq & {12{genOn}}, txTab[i][11:0])
      end
      done("transmit");
      wr(8'hc1, 16'h0005);
      wr(8'hc2, 16'h00c9);
      `CHK(scanEn, 1'b1)
      `CHK(scanFreq, 12'h29e)
      tone(6'h01, 8'hc9);
      rdChk(8'hc6, 16'h0800, 16'h0800);
      tone(6'h00, 8'h00);
      tone(6'h28, 8'hf0);
      tone(6'h00, 8'h00);
      tone(6'h05, 8'hff);
      tone(6'h00, 8'h00);
      tone(6'h3c, 8'hff);
      tone(6'h00, 8'h00);
      tone(6'h01, 8'hc9);
      tone(6'h05, 8'hc9);
      rdChk(8'hcc, 16'h00ff, 16'h00ff);
      tone(6'h00, 8'h00);
      done("detect");
      wr(8'hc2, 16'h0000);
      `CHK(scanFreq, 12'h000)
      tone(6'h28, 8'hf0);
      tone(6'h00, 8'h00);
      tone(6'h01, 8'h00);
      rdChk(8'hcc, 16'h00ff, 16'h0000);
      tone(6'h00, 8'h00);
      done("select none");
      wr(8'hc2, 16'h00c8);
      `CHK(scanAll, 1'b1)
      rdChk(8'hc2, 16'hffff, 16'h0000);
      autoAdopt <= 1'b1;
      tone(6'h07, 8'hcf);
      `CHK(scanAll, 1'b0)
      `CHK(scanFreq, 12'h356)
      autoAdopt <= 1'b0;
      tone(6'h00, 8'h00);
      tone(6'h28, 8'hf0);
      tone(6'h00, 8'h00);
      wr(8'hc1, 16'h0004);
      wr(8'hc2, 16'h00c8);
      `CHK(scanEn, 1'b0)
      `CHK(scanAll, 1'b0)
      tone(6'h01, 8'h00);
      rdChk(8'hcc, 16'h00ff, 16'h0000);
      rxTone <= 6'h00;
      done("learning");
      wr(8'hc1, 16'h0002);
      csFeed(24'h763813, 23, 1'b0);
      `CHK(hit, 1'b1)
      csFeed(24'h763813, 23, 1'b1);
      `CHK(hit, 1'b1)
      cs24 <= 1'b1;
      csPattern <= 24'hb1c0de;
      csFeed(24'hb1c0de, 24, 1'b0);
      `CHK(hit, 1'b1)
      csFeed(24'h000000, 24, 1'b0);
      `CHK(hit, 1'b0)
      wr(8'hc1, 16'h0003);
      csFeed(24'hb1c0de, 24, 1'b0);
      `CHK(hit, 1'b0)
      done("code squelch");
      endSim();
   end
endmodule : subaudio_tone_select_report_tb
